//--- logic/bcs_pkg.sv
// Constants, field layout and types of the boot configuration selector
package bcs_pkg;
   localparam logic [7:0]  OFS_RSR        = 8'h00;
   localparam logic [7:0]  OFS_REQ        = 8'h04;
   localparam logic [7:0]  OFS_STS        = 8'h08;
   localparam logic [7:0]  OFS_ECFG       = 8'h0C;
   localparam int          RSR_CODE_LSB   = 0;
   localparam int          RSR_BRK        = 4;
   localparam int          RSR_DBG        = 5;
   localparam int          RSR_CAUSE_LSB  = 8;
   localparam int          RSR_PLL_LSB    = 16;
   localparam int          REQ_CODE_LSB   = 0;
   localparam int          REQ_BRK        = 4;
   localparam int          REQ_DBG        = 5;
   localparam int          REQ_SOFT_BOOT_SELECT     = 6;
   localparam int          REQ_GO         = 31;
   localparam int          STS_DONE       = 0;
   localparam int          STS_CFGOK      = 1;
   localparam int          STS_ACT_LSB    = 4;
   localparam logic [3:0]  RST_SW_CODE    = 4'h0;
   localparam logic        RST_SW_BIT     = 1'b1;
   localparam int          CAUSE_W        = 5;
   localparam int          CAUSE_POR      = 0;
   localparam int          CAUSE_HARD     = 1;
   localparam int          CAUSE_WDT      = 2;
   localparam int          CAUSE_WAKE     = 3;
   localparam int          CAUSE_SOFT     = 4;
   localparam int          PLL_W          = 3;
   localparam logic [31:0] PC_BOOT_ROM    = 32'hBFFF_FFFC;
   localparam logic [31:0] PC_EXT         = 32'hA000_0000;
   localparam logic [31:0] PC_EMU         = 32'hBE00_0000;
   localparam logic [31:0] ADDR_EXT_CFG   = 32'hA000_0004;
   localparam logic [2:0]  CODE_ROM0      = 3'h0;
   localparam logic [2:0]  CODE_ROM1      = 3'h1;
   localparam logic [2:0]  CODE_ROM2      = 3'h2;
   localparam logic [2:0]  CODE_EXT_DIR   = 3'h4;
   localparam logic [2:0]  CODE_EXT_PER   = 3'h5;
   localparam int          CLK_NS         = 10;
   localparam int          RST_SEQ_NS     = 40;
   localparam logic [3:0]  RST_SEQ_CYC    =
      4'((RST_SEQ_NS + CLK_NS - 1) / CLK_NS);

   typedef enum logic [2:0] {
      ACT_ROM, ACT_EXT, ACT_RSVD, ACT_HALT, ACT_EMU, ACT_TRI
   } bcs_action_t;

   typedef enum logic [3:0] {
      SQ_RESET, SQ_SELECT, SQ_SETTLE, SQ_DISPATCH,
      SQ_CFG_RD, SQ_FETCH, SQ_RUN, SQ_HALT, SQ_TRI
   } bcs_seq_t;
endpackage : bcs_pkg

//--- logic/bcs_boot_if.sv
// Selected boot settings and their decoded start action
`timescale 1ns/10ps
`default_nettype none
interface bcs_boot_if;
   logic                 dbg;
   logic                 brk;
   logic [3:0]           code;
   bcs_pkg::bcs_action_t act;
   logic [31:0]          pc;
   logic                 ebu_en;
   logic                 ebu_mst;
   logic                 ebu_per;
   modport src (output dbg, brk, code,
                input  act, pc, ebu_en, ebu_mst, ebu_per);
   modport dec (input  dbg, brk, code,
                output act, pc, ebu_en, ebu_mst, ebu_per);
endinterface : bcs_boot_if
`default_nettype wire

//--- logic/bcs_strap_latch.sv
// Strap synchroniser and power-on reset transparent latches
`timescale 1ns/10ps
`default_nettype none
module bcs_strap_latch (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       power_on_reset_pin_n,
   input  wire logic       debug_enable_strap,
   input  wire logic       break_strap,
   input  wire logic [3:0] boot_select_strap,
   input  wire logic [2:0] pll_cfg_strap,
   output logic            por_active,
   output logic            por_release,
   output logic            hw_debug_enable_latch,
   output logic            hw_break_latch,
   output logic [3:0]      hw_boot_select_code,
   output logic [2:0]      pll_cfg
);
   typedef struct packed {
      logic [9:0] s1;
      logic [9:0] s2;
      logic       act;
      logic       rel;
      logic [8:0] lat;
   } bcs_strap_st_t;

   bcs_strap_st_t st_r;
   bcs_strap_st_t st_nxt;

   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = {power_on_reset_pin_n, debug_enable_strap, break_strap,
                   boot_select_strap, pll_cfg_strap};
      st_nxt.s2 = st_r.s1;
      st_nxt.act = ~st_r.s2[9];
      st_nxt.rel = st_r.act & st_r.s2[9];
      // Transparent only while power-on reset is held; closes on release
      if (~st_r.s2[9]) begin
         st_nxt.lat = st_r.s2[8:0]; // [RULE_01]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r     <= '0;
         st_r.act <= 1'b1;
      end else begin
         st_r <= st_nxt; // [RULE_14]
      end
   end

   assign por_active            = st_r.act;
   assign por_release           = st_r.rel;
   assign hw_debug_enable_latch = st_r.lat[8];
   assign hw_break_latch        = st_r.lat[7];
   assign hw_boot_select_code   = st_r.lat[6:3];
   assign pll_cfg               = st_r.lat[2:0];
endmodule : bcs_strap_latch
`default_nettype wire

//--- logic/bcs_boot_decode.sv
// Decoder from selected boot settings to start action
`timescale 1ns/10ps
`default_nettype none
module bcs_boot_decode (
   input  wire logic hclk,
   input  wire logic hresetn,
   bcs_boot_if.dec   bus
);
   typedef struct packed {
      bcs_pkg::bcs_action_t act;
      logic [31:0]          pc;
      logic                 ebu_en;
      logic                 ebu_mst;
      logic                 ebu_per;
   } bcs_dec_st_t;

   bcs_dec_st_t st_r;
   bcs_dec_st_t st_nxt;

   always_comb begin
      st_nxt = '0;
      st_nxt.act = bcs_pkg::ACT_HALT;
      unique case ({bus.dbg, bus.brk})
         2'b11: begin
            unique case (bus.code[2:0])
               bcs_pkg::CODE_ROM0, bcs_pkg::CODE_ROM1,
               bcs_pkg::CODE_ROM2: begin
                  st_nxt.act = bcs_pkg::ACT_ROM; // [RULE_06]
                  st_nxt.pc  = bcs_pkg::PC_BOOT_ROM;
               end
               bcs_pkg::CODE_EXT_DIR: begin
                  st_nxt.act     = bcs_pkg::ACT_EXT; // [RULE_07]
                  st_nxt.pc      = bcs_pkg::PC_EXT;
                  st_nxt.ebu_en  = 1'b1;
                  st_nxt.ebu_mst = bus.code[3];
               end
               bcs_pkg::CODE_EXT_PER: begin
                  st_nxt.act     = bcs_pkg::ACT_EXT; // [RULE_08]
                  st_nxt.pc      = bcs_pkg::PC_EXT;
                  st_nxt.ebu_en  = 1'b1;
                  st_nxt.ebu_mst = bus.code[3];
                  st_nxt.ebu_per = 1'b1;
               end
               // Reserved codes park the core instead of guessing
               default: st_nxt.act = bcs_pkg::ACT_RSVD; // [RULE_09]
            endcase
         end
         2'b01: begin
            st_nxt.act = bcs_pkg::ACT_HALT; // [RULE_11]
            if (bus.code[2:0] == bcs_pkg::CODE_EXT_DIR ||
                bus.code[2:0] == bcs_pkg::CODE_EXT_PER) begin
               st_nxt.ebu_en  = 1'b1; // [RULE_10]
               st_nxt.ebu_mst = bus.code[3];
            end
         end
         2'b00: begin
            st_nxt.act = bcs_pkg::ACT_EMU; // [RULE_12]
            st_nxt.pc  = bcs_pkg::PC_EMU;
         end
         2'b10: st_nxt.act = bcs_pkg::ACT_TRI; // [RULE_13]
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r     <= '0;
         st_r.act <= bcs_pkg::ACT_HALT;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.act     = st_r.act;
   assign bus.pc      = st_r.pc;
   assign bus.ebu_en  = st_r.ebu_en;
   assign bus.ebu_mst = st_r.ebu_mst;
   assign bus.ebu_per = st_r.ebu_per;
endmodule : bcs_boot_decode
`default_nettype wire

//--- logic/bcs_top.sv
// Boot configuration selector: straps, soft boot register, start sequencer
// How it works
// [RULE_01] Clock-synthesizer straps latch only during power-on reset.
// [RULE_02] Debug, break and select straps land in the reset status register.
// [RULE_03] Hardware-caused resets boot from the latched strap settings.
// [RULE_04] Request register holds six soft bits matching the latched ones: four code bits, break and debug.
// [RULE_05] Soft select bit set means the soft reset boots from soft bits.
// [RULE_06] Normal boot with low codes 0, 1, 2 starts from boot ROM.
// [RULE_07] Low code 4 boots external memory directly; top bit picks master.
// [RULE_08] Low code 5 boots external memory via peripheral bus.
// [RULE_09] Reserved low codes must never be presented in normal boot.
// [RULE_10] Halt mode with code 4 or 5 keeps external bus unit on.
// [RULE_11] Other halt-mode codes halt with external bus unit disabled.
// [RULE_12] Debug and break both low start in emulator space.
// [RULE_13] Debug high, break low tri-states chip and holds low power.
// [RULE_14] Select latches are transparent in power-on reset, close at end.
// [RULE_15] Latched values change only with another power-on reset.
// [RULE_16] Software can read both soft settings and latched straps.
// [RULE_17] External boot reads the config word, then the first fetch.
// [RULE_18] Debug feature latch is caught at power-on release only.
// [RULE_19] Soft settings take effect only on a software reset.
// [RULE_20] Selected settings stay frozen until the first fetch ends.
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module bcs_top (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        power_on_reset_pin_n,
   input  wire logic        debug_enable_strap,
   input  wire logic        break_strap,
   input  wire logic [3:0]  boot_select_strap,
   input  wire logic [2:0]  pll_cfg_strap,
   input  wire logic        hard_reset_req,
   input  wire logic        watchdog_reset_req,
   input  wire logic        wakeup_reset_req,
   input  wire logic        ext_rd_ack,
   input  wire logic [31:0] ext_rd_data,
   output logic [2:0]       pll_cfg,
   output logic             debug_features_en,
   output logic             cpu_run,
   output logic             cpu_halt,
   output logic [31:0]      start_pc,
   output logic             external_bus_unit_en,
   output logic             external_bus_unit_master,
   output logic             external_bus_unit_via_periph,
   output logic             chip_tristate,
   output logic             low_power_hold,
   output logic             ext_rd_req,
   output logic [31:0]      ext_rd_addr,
   output logic             boot_done
);
   typedef struct packed {
      logic                         wr_pend;
      logic [7:0]                   wr_ofs;
      logic [31:0]                  rdata;
      logic                         ready;
      logic [3:0]                   sw_code;
      logic                         sw_brk;
      logic                         sw_dbg;
      logic                         sw_boot;
      logic [bcs_pkg::CAUSE_W-1:0]  cause;
      logic                         use_sw;
      bcs_pkg::bcs_seq_t            seq;
      logic [3:0]                   cnt;
      logic                         c_dbg;
      logic                         c_brk;
      logic [3:0]                   c_code;
      bcs_pkg::bcs_action_t         act;
      logic                         run;
      logic                         halt;
      logic [31:0]                  pc;
      logic                         ebu_en;
      logic                         ebu_mst;
      logic                         ebu_per;
      logic                         tri_st;
      logic                         lowpwr;
      logic                         ext_req;
      logic [31:0]                  ext_addr;
      logic [31:0]                  ecfg;
      logic                         cfg_ok;
      logic                         done;
      logic                         dbg_feat;
   } bcs_top_st_t;

   bcs_top_st_t st_r;
   bcs_top_st_t st_nxt;

   logic       por_active;
   logic       por_release;
   logic       hw_debug_enable_latch;
   logic       hw_break_latch;
   logic [3:0] hw_boot_select_code;
   logic [2:0] pll_lat;
   logic       addr_ph;
   logic       soft_go;

   bcs_boot_if u_if ();

   bcs_strap_latch u_strap (
      .hclk                  (hclk),
      .hresetn               (hresetn),
      .power_on_reset_pin_n  (power_on_reset_pin_n),
      .debug_enable_strap    (debug_enable_strap),
      .break_strap           (break_strap),
      .boot_select_strap     (boot_select_strap),
      .pll_cfg_strap         (pll_cfg_strap),
      .por_active            (por_active),
      .por_release           (por_release),
      .hw_debug_enable_latch (hw_debug_enable_latch),
      .hw_break_latch        (hw_break_latch),
      .hw_boot_select_code   (hw_boot_select_code),
      .pll_cfg               (pll_lat)
   );

   bcs_boot_decode u_dec (
      .hclk    (hclk),
      .hresetn (hresetn),
      .bus     (u_if)
   );

   // Frozen selection drives the decoder; it moves only in SQ_SELECT
   assign u_if.dbg  = st_r.c_dbg; // [RULE_20]
   assign u_if.brk  = st_r.c_brk;
   assign u_if.code = st_r.c_code;

   assign addr_ph = hsel & hready & htrans[1];
   assign soft_go = st_r.wr_pend & (st_r.wr_ofs == bcs_pkg::OFS_REQ) &
                    hwdata[bcs_pkg::REQ_GO];

   // Read mux of the register file
   function automatic logic [31:0] rd_mux(input bcs_top_st_t s,
                                          input logic [7:0]  ofs,
                                          input logic        dbg,
                                          input logic        brk,
                                          input logic [3:0]  code,
                                          input logic [2:0]  pll);
      logic [31:0] v;
      v = '0;
      unique case (ofs)
         bcs_pkg::OFS_RSR: begin
            v[bcs_pkg::RSR_CODE_LSB +: 4] = code; // [RULE_02]
            v[bcs_pkg::RSR_BRK] = brk;
            v[bcs_pkg::RSR_DBG] = dbg;
            v[bcs_pkg::RSR_CAUSE_LSB +: bcs_pkg::CAUSE_W] = s.cause;
            v[bcs_pkg::RSR_PLL_LSB +: bcs_pkg::PLL_W] = pll;
         end
         bcs_pkg::OFS_REQ: begin
            v[bcs_pkg::REQ_CODE_LSB +: 4] = s.sw_code; // [RULE_16]
            v[bcs_pkg::REQ_BRK]    = s.sw_brk;
            v[bcs_pkg::REQ_DBG]    = s.sw_dbg;
            v[bcs_pkg::REQ_SOFT_BOOT_SELECT] = s.sw_boot;
         end
         bcs_pkg::OFS_STS: begin
            v[bcs_pkg::STS_DONE]  = s.done;
            v[bcs_pkg::STS_CFGOK] = s.cfg_ok;
            v[bcs_pkg::STS_ACT_LSB +: 3] = s.act;
         end
         bcs_pkg::OFS_ECFG: v = s.ecfg;
         default: v = '0;
      endcase
      return v;
   endfunction : rd_mux

   always_comb begin
      st_nxt = st_r;
      st_nxt.ready = 1'b1;
      // Bus slave: zero wait states, read data fetched in address phase
      st_nxt.wr_pend = addr_ph & hwrite;
      st_nxt.wr_ofs  = haddr[7:0];
      if (addr_ph & ~hwrite) begin
         st_nxt.rdata = rd_mux(st_r, haddr[7:0], hw_debug_enable_latch,
                               hw_break_latch, hw_boot_select_code,
                               pll_lat);
      end
      // Only the request register is writable; straps are never written
      if (st_r.wr_pend && st_r.wr_ofs == bcs_pkg::OFS_REQ) begin
         st_nxt.sw_code = hwdata[bcs_pkg::REQ_CODE_LSB +: 4]; // [RULE_04]
         st_nxt.sw_brk  = hwdata[bcs_pkg::REQ_BRK];
         st_nxt.sw_dbg  = hwdata[bcs_pkg::REQ_DBG];
         st_nxt.sw_boot = hwdata[bcs_pkg::REQ_SOFT_BOOT_SELECT]; // [RULE_15]
      end
      if (por_release) begin
         st_nxt.dbg_feat = ~hw_debug_enable_latch; // [RULE_18]
      end
      // Reset entry; power-on outranks the others
      if (por_active || hard_reset_req || watchdog_reset_req ||
          wakeup_reset_req || soft_go) begin
         st_nxt.seq      = bcs_pkg::SQ_RESET;
         st_nxt.cnt      = '0;
         st_nxt.cause    = '0;
         st_nxt.use_sw   = 1'b0;
         st_nxt.run      = 1'b0;
         st_nxt.halt     = 1'b0;
         st_nxt.ebu_en   = 1'b0;
         st_nxt.ebu_mst  = 1'b0;
         st_nxt.ebu_per  = 1'b0;
         st_nxt.tri_st   = 1'b0;
         st_nxt.lowpwr   = 1'b0;
         st_nxt.ext_req  = 1'b0;
         st_nxt.done     = 1'b0;
         st_nxt.cfg_ok   = 1'b0;
         if (por_active) begin
            st_nxt.cause[bcs_pkg::CAUSE_POR] = 1'b1;
            st_nxt.sw_code = bcs_pkg::RST_SW_CODE;
            st_nxt.sw_brk  = bcs_pkg::RST_SW_BIT;
            st_nxt.sw_dbg  = bcs_pkg::RST_SW_BIT;
            st_nxt.sw_boot = 1'b0;
         end else if (hard_reset_req) begin
            st_nxt.cause[bcs_pkg::CAUSE_HARD] = 1'b1;
         end else if (watchdog_reset_req) begin
            st_nxt.cause[bcs_pkg::CAUSE_WDT] = 1'b1;
         end else if (wakeup_reset_req) begin
            st_nxt.cause[bcs_pkg::CAUSE_WAKE] = 1'b1;
         end else begin
            st_nxt.cause[bcs_pkg::CAUSE_SOFT] = 1'b1;
            // Soft bits are taken from this same write
            st_nxt.use_sw  = hwdata[bcs_pkg::REQ_SOFT_BOOT_SELECT]; // [RULE_05]
         end
      end else begin
         unique case (st_r.seq)
            bcs_pkg::SQ_RESET: begin
               st_nxt.cnt = 4'(st_r.cnt + 4'h1);
               if (st_r.cnt == bcs_pkg::RST_SEQ_CYC - 4'h1) begin
                  st_nxt.seq = bcs_pkg::SQ_SELECT;
               end
            end
            bcs_pkg::SQ_SELECT: begin
               if (st_r.use_sw && st_r.cause[bcs_pkg::CAUSE_SOFT]) begin
                  st_nxt.c_dbg  = st_r.sw_dbg; // [RULE_19]
                  st_nxt.c_brk  = st_r.sw_brk;
                  st_nxt.c_code = st_r.sw_code;
               end else begin
                  st_nxt.c_dbg  = hw_debug_enable_latch; // [RULE_03]
                  st_nxt.c_brk  = hw_break_latch;
                  st_nxt.c_code = hw_boot_select_code;
               end
               st_nxt.seq = bcs_pkg::SQ_SETTLE;
            end
            // Decoder output is registered; wait one cycle for it
            bcs_pkg::SQ_SETTLE: st_nxt.seq = bcs_pkg::SQ_DISPATCH;
            bcs_pkg::SQ_DISPATCH: begin
               st_nxt.act     = u_if.act;
               st_nxt.pc      = u_if.pc;
               st_nxt.ebu_en  = u_if.ebu_en;
               st_nxt.ebu_mst = u_if.ebu_mst;
               st_nxt.ebu_per = u_if.ebu_per;
               unique case (u_if.act)
                  bcs_pkg::ACT_ROM, bcs_pkg::ACT_EMU: begin
                     st_nxt.run  = 1'b1;
                     st_nxt.done = 1'b1;
                     st_nxt.seq  = bcs_pkg::SQ_RUN;
                  end
                  bcs_pkg::ACT_EXT: begin
                     st_nxt.ext_req  = 1'b1; // [RULE_17]
                     st_nxt.ext_addr = bcs_pkg::ADDR_EXT_CFG;
                     st_nxt.seq      = bcs_pkg::SQ_CFG_RD;
                  end
                  bcs_pkg::ACT_HALT, bcs_pkg::ACT_RSVD: begin
                     st_nxt.halt = 1'b1;
                     st_nxt.done = 1'b1;
                     st_nxt.seq  = bcs_pkg::SQ_HALT;
                  end
                  bcs_pkg::ACT_TRI: begin
                     st_nxt.tri_st = 1'b1;
                     st_nxt.lowpwr = 1'b1;
                     st_nxt.done   = 1'b1;
                     st_nxt.seq    = bcs_pkg::SQ_TRI;
                  end
               endcase
            end
            bcs_pkg::SQ_CFG_RD: begin
               if (ext_rd_ack) begin
                  st_nxt.ecfg     = ext_rd_data; // [RULE_17]
                  st_nxt.cfg_ok   = 1'b1;
                  st_nxt.ext_addr = bcs_pkg::PC_EXT;
                  st_nxt.seq      = bcs_pkg::SQ_FETCH;
               end
            end
            bcs_pkg::SQ_FETCH: begin
               if (ext_rd_ack) begin
                  st_nxt.ext_req = 1'b0;
                  st_nxt.run     = 1'b1;
                  st_nxt.done    = 1'b1;
                  st_nxt.seq     = bcs_pkg::SQ_RUN;
               end
            end
            bcs_pkg::SQ_RUN, bcs_pkg::SQ_HALT, bcs_pkg::SQ_TRI: begin
               st_nxt.seq = st_r.seq;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r        <= '0;
         st_r.ready  <= 1'b1;
         st_r.sw_brk <= bcs_pkg::RST_SW_BIT;
         st_r.sw_dbg <= bcs_pkg::RST_SW_BIT;
         st_r.act    <= bcs_pkg::ACT_HALT;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hreadyout                    = st_r.ready;
   assign hresp                        = 1'b0;
   assign hrdata                       = st_r.rdata;
   assign pll_cfg                      = pll_lat;
   assign debug_features_en            = st_r.dbg_feat;
   assign cpu_run                      = st_r.run;
   assign cpu_halt                     = st_r.halt;
   assign start_pc                     = st_r.pc;
   assign external_bus_unit_en         = st_r.ebu_en;
   assign external_bus_unit_master     = st_r.ebu_mst;
   assign external_bus_unit_via_periph = st_r.ebu_per;
   assign chip_tristate                = st_r.tri_st;
   assign low_power_hold               = st_r.lowpwr;
   assign ext_rd_req                   = st_r.ext_req;
   assign ext_rd_addr                  = st_r.ext_addr;
   assign boot_done                    = st_r.done;
endmodule : bcs_top
`default_nettype wire

//--- tb/bcs_ext_mem.sv
// Far-side model: external boot memory answering after a set latency
`timescale 1ns/10ps
`default_nettype none
module bcs_ext_mem #(parameter int LAT = 3) (
   input  wire logic        hclk,
   input  wire logic        ext_rd_req,
   input  wire logic [31:0] ext_rd_addr,
   output var  logic        ext_rd_ack = 1'b0,
   output var  logic [31:0] ext_rd_data = 32'h0
);
   int n = 0;
   // Data toggles when no answer is due, so stale data never looks valid
   always @(posedge hclk) begin
      ext_rd_ack <= 1'b0;
      ext_rd_data <= ~ext_rd_data;
      n <= (ext_rd_req && !ext_rd_ack) ? n + 1 : 0;
      if (ext_rd_req && !ext_rd_ack && n == LAT) begin
         ext_rd_ack <= 1'b1;
         ext_rd_data <= ext_rd_addr ^ 32'h5A5A_0000;
      end
   end
endmodule : bcs_ext_mem
`default_nettype wire

//--- tb/bcs_props.sv
// Checker of the boot selector outputs
`timescale 1ns/10ps
`default_nettype none
module bcs_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        power_on_reset_pin_n,
   input wire logic [2:0]  pll_cfg,
   input wire logic        debug_features_en,
   input wire logic        cpu_run,
   input wire logic        cpu_halt,
   input wire logic [31:0] start_pc,
   input wire logic        external_bus_unit_via_periph,
   input wire logic        chip_tristate,
   input wire logic        low_power_hold,
   input wire logic        ext_rd_req,
   input wire logic        ext_rd_ack,
   input wire logic [31:0] ext_rd_addr
);
   logic [2:0] por_cnt_r;
   // Counts cycles since the pin rose, past the sync and latch delay
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn) por_cnt_r <= 3'h0;
      else if (!power_on_reset_pin_n) por_cnt_r <= 3'h0;
      else if (por_cnt_r != 3'h7) por_cnt_r <= por_cnt_r + 3'h1;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence cfg_s; ext_rd_req && ext_rd_addr == bcs_pkg::ADDR_EXT_CFG;
   endsequence
   sequence fetch_s; ext_rd_req && ext_rd_addr == bcs_pkg::PC_EXT;
   endsequence
   pll_hold_a: assert property (
      por_cnt_r == 3'h7 |-> $stable(pll_cfg)) else $error("pll moved");
   dbg_hold_a: assert property (
      por_cnt_r == 3'h7 |-> $stable(debug_features_en)) else $error("dbg");
   tri_state_a: assert property (
      chip_tristate |-> low_power_hold && !cpu_run && !cpu_halt)
      else $error("tri");
   halt_mode_a: assert property (
      cpu_halt |-> !cpu_run && !external_bus_unit_via_periph)
      else $error("halt");
   cfg_first_a: assert property (
      $rose(ext_rd_req) |-> cfg_s) else $error("cfg first");
   req_hold_a: assert property (
      ext_rd_req && !ext_rd_ack |=> ext_rd_req && $stable(ext_rd_addr))
      else $error("req hold");
   cfg_fetch_a: assert property (
      cfg_s ##0 ext_rd_ack |=> fetch_s) else $error("fetch");
   fetch_run_a: assert property (
      fetch_s ##0 ext_rd_ack |=> cpu_run && start_pc == bcs_pkg::PC_EXT)
      else $error("run");
endmodule : bcs_props
bind bcs_top bcs_props u_props (.*);
`default_nettype wire

//--- tb/tb_boot_config_select.sv
// Bench: power-on, soft and hardware resets of the boot selector
`timescale 1ns/10ps
`default_nettype none
module tb_boot_config_select;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
   logic        power_on_reset_pin_n = 0, debug_enable_strap = 1;
   logic        break_strap = 1, hard_reset_req = 0;
   logic        watchdog_reset_req = 0, wakeup_reset_req = 0;
   logic [3:0]  boot_select_strap = 4'hC;
   logic [2:0]  pll_cfg_strap = 3'h5, pll_cfg;
   logic        hreadyout, hresp, debug_features_en, cpu_run, cpu_halt;
   logic        external_bus_unit_en, external_bus_unit_master, boot_done;
   logic        external_bus_unit_via_periph, chip_tristate, low_power_hold;
   logic        ext_rd_req, ext_rd_ack;
   logic [31:0] hrdata, start_pc, ext_rd_addr, ext_rd_data;
   // Soft bits, expected {run,halt,en,master,periph,tri}, start address
   logic [47:0] tbl [10] = '{48'h3020_BFFF_FFFC, 48'h3120_BFFF_FFFC,
      48'h3220_BFFF_FFFC, 48'h3428_A000_0000, 48'h3D2E_A000_0000,
      48'h1518_0000_0000, 48'h1C1C_0000_0000, 48'h1210_0000_0000,
      48'h0720_BE00_0000, 48'h2301_0000_0000};
   int          mismatches = 0, checks = 0, cyc = 0;
   bcs_top u_dut (.hready(hreadyout), .hsize(3'h2), .*);
   bcs_ext_mem u_mem (.*);
   task automatic give_verdict;
      if (mismatches == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
      hsel <= 1;
      haddr <= 32'(a);
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic boot;
      repeat (2) @(posedge hclk);
      while (boot_done !== 1'b1) @(posedge hclk);
   endtask : boot
   // Bus unit bits are left open by the rules for ROM, emulator and tri-state
   task automatic act(input logic [7:0] f, input logic [31:0] pc);
      logic [5:0] m;
      m = (f[0] || (f[5] && pc != bcs_pkg::PC_EXT)) ? 6'h31 : 6'h3F;
      cmp(32'(m & {cpu_run, cpu_halt, external_bus_unit_en,
         external_bus_unit_master, external_bus_unit_via_periph,
         chip_tristate}), 32'(m & f[5:0]));
      if (f[5]) cmp(start_pc, pc);
   endtask : act
   initial forever #5 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 5000) begin
         mismatches++;
         give_verdict();
      end
   end
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1;
      repeat (4) @(posedge hclk);
      power_on_reset_pin_n <= 1;
      boot();
      act(8'h2C, bcs_pkg::PC_EXT);
      bus(0, bcs_pkg::OFS_RSR, 0);
      cmp(q, 32'h0005_013C);
      bus(0, bcs_pkg::OFS_ECFG, 0);
      cmp(q, bcs_pkg::ADDR_EXT_CFG ^ 32'h5A5A_0000);
      boot_select_strap <= 4'h0;
      debug_enable_strap <= 0;
      pll_cfg_strap <= 3'h2;
      foreach (tbl[i]) begin
         bus(1, bcs_pkg::OFS_REQ,
             32'h8000_0040 | 32'(tbl[i][47:40]));
         boot();
         act(tbl[i][39:32], tbl[i][31:0]);
         bus(0, bcs_pkg::OFS_REQ, 0);
         cmp(q, 32'h40 | 32'(tbl[i][47:40]));
      end
      bus(1, bcs_pkg::OFS_REQ, 32'h8000_0007);
      boot();
      act(8'h2C, bcs_pkg::PC_EXT);
      bus(1, bcs_pkg::OFS_RSR, 32'hFFFF_FFFF);
      for (int i = 0; i < 3; i++) begin
         {wakeup_reset_req, watchdog_reset_req, hard_reset_req} <= 3'(1 << i);
         @(posedge hclk);
         {wakeup_reset_req, watchdog_reset_req, hard_reset_req} <= 3'h0;
         boot();
         act(8'h2C, bcs_pkg::PC_EXT);
         bus(0, bcs_pkg::OFS_RSR, 0);
         cmp(q, 32'h0005_003C | (32'h200 << i));
      end
      cmp(32'({pll_cfg, debug_features_en, hresp}), 32'h14);
      bus(0, 8'h10, 0);
      cmp(q, 32'h0);
      give_verdict();
   end
endmodule : tb_boot_config_select
`default_nettype wire
